// >>> bfs_pkg.sv
// Package with the constants and types of the buck fault sequencer.
package bfs_pkg;

  // Clock rate of clk_sys.
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS  = 10;

  // Times as printed, and the cycle counts derived from them.
  localparam int unsigned MIN_OFF_NS     = 330;
  localparam int unsigned OV_BLANK_NS    = 5_000;
  localparam int unsigned UV_BLANK_NS    = 20_000;
  localparam int unsigned START_DELAY_NS = 1_520_000;
  localparam int unsigned MIN_OFF_CYC    = (MIN_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OV_BLANK_CYC   = OV_BLANK_NS / CLK_PERIOD_NS;
  localparam int unsigned UV_BLANK_CYC   = UV_BLANK_NS / CLK_PERIOD_NS;
  localparam int unsigned START_DELAY_CYC = START_DELAY_NS / CLK_PERIOD_NS;

  // Switching frequency limits and the period range in clock cycles.
  localparam int unsigned FSW_MIN_KHZ    = 100;
  localparam int unsigned FSW_MAX_KHZ    = 500;
  localparam int unsigned PER_MAX_CYC    = CLK_HZ / (FSW_MIN_KHZ * 1000);
  localparam int unsigned PER_MIN_CYC    = CLK_HZ / (FSW_MAX_KHZ * 1000);
  localparam int unsigned PER_W          = 10;

  // Restart wait in soft-start durations, and the overcurrent window.
  localparam int unsigned RESTART_SS_MULT = 4;
  localparam int unsigned OC_TRIP_CNT    = 3;
  localparam int unsigned OC_WINDOW      = 8;

  // Register byte offsets on the bus.
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_PERIOD = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_FAULT  = 8'h0C;
  localparam logic [7:0] ADDR_SSLEN  = 8'h10;

  // Reset values of the writable registers.
  localparam logic             CTRL_EN_RST = 1'b1;
  localparam logic [PER_W-1:0] PERIOD_RST  = 10'h3E8;

  // Fault register bit positions.
  localparam int unsigned FLT_OC = 0;
  localparam int unsigned FLT_OV = 1;
  localparam int unsigned FLT_UV = 2;
  localparam int unsigned FLT_TH = 3;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_DISABLED    = 3'b000,
    ST_START_DELAY = 3'b001,
    ST_SOFT_START  = 3'b010,
    ST_REGULATE    = 3'b011,
    ST_FAULT_WAIT  = 3'b100
  } bfs_state_t;

  // Comparator and pin results from the analog side.
  typedef struct packed {
    logic en_open;
    logic en_deep_above;
    logic en_above_thr;
    logic vin_uvlo_ok;
    logic vreg_uvlo_ok;
    logic fb_over_ov;
    logic fb_under_uv;
    logic fb_above_ref;
    logic ss_end;
    logic pwm_end;
    logic low_side_overcurrent;
    logic high_side_overcurrent;
    logic thermal_trip;
    logic vout_above_hi;
    logic vout_above_lo;
    logic power_good_in;
  } bfs_sense_t;

endpackage

// >>> bfs_sequencer.sv
// Control and protection sequencer of a synchronous step-down converter.
// Function
// - Every switching cycle keeps the high-side off for at least 330 ns.
// - Switching period is programmable for 100 kHz to 500 kHz.
// - Ramp is a sawtooth at the switching frequency, VIN/30 amplitude, 0.17 V offset.
// - Enable above threshold with both supply lockouts cleared starts the soft-start.
// - Enable below 0.82 V keeps regulator and bias off.
// - Gate drives stay off until enable crosses its threshold.
// - A floating enable pin counts as asserted.
// - Only overcurrent is watched during any soft-start.
// - Restart mode turns both switches off and pulls power-good low.
// - Restart mode waits four soft-start durations before a new soft-start.
// - Soft-start after a restart wait watches only overcurrent.
// - Feedback above 1.625 V for over 5 us sets over-voltage, power-good low.
// - Over-voltage turns high-side off and holds low-side on.
// - After over-voltage, restart mode follows once feedback is under-voltage.
// - Feedback below 0.875 V over 20 us sets under-voltage and restarts.
// - Under-voltage watch is off during soft-start.
// - After enable the regulator runs from the high-voltage input.
// - After soft-start and regulation, output above 7.2 V selects bootstrap supply.
// - Supply selection uses about 0.9 V hysteresis.
// - Output programmed below 7.2 V keeps the high-voltage supply.
// - Pre-biased output above target suppresses switching until it drops below.
// - Three overcurrent events in eight cycles restart; one low-side event skips a pulse.
// - Thermal trip in regulation turns both switches off, power-good low, restart mode.
// - Soft-start ramp begins about 1.52 ms after enable.
//
// Decided for this implementation: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
module bfs_sequencer
  import bfs_pkg::*;
#(
  parameter int unsigned START_DELAY = START_DELAY_CYC,
  parameter int unsigned SS_W        = 24
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire bfs_sense_t       sense_in,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  output logic                  hs_gate_out,
  output logic                  ls_gate_out,
  output logic                  power_good_out_o,
  output logic                  power_good_out_oe,
  output logic                  internal_regulator_on,
  output logic                  bootstrap_supply_sel,
  output logic      [PER_W-1:0] ramp_phase
);

  // Refuse settings the counters cannot serve.
  if (START_DELAY < 1 || START_DELAY > 262143 || SS_W < 8 || SS_W > 29) begin : g_chk
    $error("bfs_sequencer: parameter out of range");
  end

  // Two-flop synchroniser for all analog comparator results.
  bfs_sense_t sync1_r;
  bfs_sense_t sn;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync1_r <= '0;
      sn      <= '0;
    end else begin
      sync1_r <= sense_in;
      sn      <= sync1_r;
    end
  end

  bfs_state_t         state_r, state_nxt;
  logic [17:0]        dly_cnt_r, dly_cnt_nxt;
  logic [SS_W-1:0]    ss_cnt_r, ss_cnt_nxt;
  logic [SS_W-1:0]    ss_len_r, ss_len_nxt;
  logic [SS_W+1:0]    wait_cnt_r, wait_cnt_nxt;
  logic               ov_lat_r, ov_lat_nxt;
  logic               prebias_r, prebias_nxt;
  logic [11:0]        ov_cnt_r, ov_cnt_nxt;
  logic [11:0]        uv_cnt_r, uv_cnt_nxt;
  logic [PER_W-1:0]   per_cnt_r, per_cnt_nxt;
  logic               hs_r, hs_nxt;
  logic               ls_r, ls_nxt;
  logic               skip_r, skip_nxt;
  logic               oc_cur_r, oc_cur_nxt;
  logic [OC_WINDOW-1:0] hist_r, hist_nxt;
  logic               ext_r, ext_nxt;
  logic               reg_on_r, reg_on_nxt;
  logic               pg_oe_r, pg_oe_nxt;
  logic               ctrl_en_r, ctrl_en_nxt;
  logic [PER_W-1:0]   period_r, period_nxt;
  logic [3:0]         fault_r, fault_nxt;
  logic [31:0]        rdat_r, rdat_nxt;
  logic               ack_r, ack_nxt;

  // Enable decoding: the pull-up makes an open pin read as enabled.
  logic en_deep;
  logic en_ok;
  assign en_deep = sn.en_deep_above | sn.en_open;
  assign en_ok   = ctrl_en_r & (sn.en_above_thr | sn.en_open)
                 & sn.vin_uvlo_ok & sn.vreg_uvlo_ok;

  // Switching period held inside the documented frequency range.
  logic [PER_W-1:0] per_eff;
  always_comb begin
    if (period_r < PER_W'(PER_MIN_CYC)) begin
      per_eff = PER_W'(PER_MIN_CYC);
    end else if (period_r > PER_W'(PER_MAX_CYC)) begin
      per_eff = PER_W'(PER_MAX_CYC);
    end else begin
      per_eff = period_r;
    end
  end

  // Overcurrent events within the sliding window of switching cycles.
  logic [3:0] oc_events;
  always_comb begin
    oc_events = {3'h0, oc_cur_r};
    for (int i = 0; i < OC_WINDOW - 1; i++) begin
      oc_events = oc_events + {3'h0, hist_r[i]};
    end
  end

  // Fault trips seen by the sequencer.
  logic oc_trip;
  logic ov_trip;
  logic uv_trip;
  logic run_on;
  assign oc_trip = oc_events >= 4'(OC_TRIP_CNT);
  assign ov_trip = ov_cnt_r == 12'(OV_BLANK_CYC);
  assign uv_trip = uv_cnt_r == 12'(UV_BLANK_CYC);
  assign run_on  = (state_r == ST_SOFT_START || state_r == ST_REGULATE) & !ov_lat_r;

  // Next state of the sequencer and its timers.
  always_comb begin
    state_nxt    = state_r;
    dly_cnt_nxt  = dly_cnt_r;
    ss_cnt_nxt   = ss_cnt_r;
    ss_len_nxt   = ss_len_r;
    wait_cnt_nxt = wait_cnt_r;
    ov_lat_nxt   = ov_lat_r;
    prebias_nxt  = prebias_r & sn.fb_above_ref;
    if (!en_deep || !en_ok) begin
      state_nxt   = ST_DISABLED;
      ov_lat_nxt  = 1'b0;
      prebias_nxt = 1'b0;
    end else begin
      unique case (state_r)
        ST_DISABLED: begin
          state_nxt   = ST_START_DELAY;
          dly_cnt_nxt = '0;
        end
        ST_START_DELAY: begin
          dly_cnt_nxt = dly_cnt_r + 18'h00001;
          if (dly_cnt_r == 18'(START_DELAY - 1)) begin
            state_nxt   = ST_SOFT_START;
            ss_cnt_nxt  = '0;
            prebias_nxt = sn.fb_above_ref;
          end
        end
        ST_SOFT_START: begin
          if (ss_cnt_r != {SS_W{1'b1}}) begin
            ss_cnt_nxt = ss_cnt_r + 1'b1;
          end
          if (oc_trip || sn.ss_end) begin
            if (ss_cnt_r > ss_len_r) begin
              ss_len_nxt = ss_cnt_r;
            end
          end
          // Only overcurrent ends a soft-start early.
          if (oc_trip) begin
            state_nxt    = ST_FAULT_WAIT;
            wait_cnt_nxt = '0;
          end else if (sn.ss_end) begin
            state_nxt = ST_REGULATE;
          end
        end
        ST_REGULATE: begin
          if (ov_trip) begin
            ov_lat_nxt = 1'b1;
          end
          if (oc_trip || uv_trip || sn.thermal_trip
              || (ov_lat_r && sn.fb_under_uv)) begin
            state_nxt    = ST_FAULT_WAIT;
            wait_cnt_nxt = '0;
            ov_lat_nxt   = 1'b0;
          end
        end
        ST_FAULT_WAIT: begin
          wait_cnt_nxt = wait_cnt_r + 1'b1;
          if (sn.thermal_trip) begin
            wait_cnt_nxt = '0;
          end else if (wait_cnt_r >= (SS_W + 2)'(RESTART_SS_MULT) * {2'b00, ss_len_r}) begin
            state_nxt   = ST_SOFT_START;
            ss_cnt_nxt  = '0;
            prebias_nxt = sn.fb_above_ref;
          end
        end
        default: state_nxt = ST_DISABLED;
      endcase
    end
  end

  // Sequencer registers.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r    <= ST_DISABLED;
      dly_cnt_r  <= '0;
      ss_cnt_r   <= '0;
      ss_len_r   <= '0;
      wait_cnt_r <= '0;
      ov_lat_r   <= 1'b0;
      prebias_r  <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      dly_cnt_r  <= dly_cnt_nxt;
      ss_cnt_r   <= ss_cnt_nxt;
      ss_len_r   <= ss_len_nxt;
      wait_cnt_r <= wait_cnt_nxt;
      ov_lat_r   <= ov_lat_nxt;
      prebias_r  <= prebias_nxt;
    end
  end

  // Blanking counters run only in regulation, so soft-start ignores them.
  always_comb begin
    ov_cnt_nxt = '0;
    uv_cnt_nxt = '0;
    if (state_r == ST_REGULATE && sn.fb_over_ov) begin
      ov_cnt_nxt = ov_trip ? ov_cnt_r : ov_cnt_r + 12'h001;
    end
    if (state_r == ST_REGULATE && sn.fb_under_uv) begin
      uv_cnt_nxt = uv_trip ? uv_cnt_r : uv_cnt_r + 12'h001;
    end
  end

  // Blanking counter registers.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ov_cnt_r <= '0;
      uv_cnt_r <= '0;
    end else begin
      ov_cnt_r <= ov_cnt_nxt;
      uv_cnt_r <= uv_cnt_nxt;
    end
  end

  // Ramp counter, gate drive and pulse skipping.
  always_comb begin
    per_cnt_nxt = (per_cnt_r >= per_eff - 1'b1) ? '0 : per_cnt_r + 1'b1;
    skip_nxt    = skip_r;
    oc_cur_nxt  = oc_cur_r;
    hist_nxt    = hist_r;
    if ((ls_r && sn.low_side_overcurrent) || (hs_r && sn.high_side_overcurrent)) begin
      oc_cur_nxt = 1'b1;
    end
    if (ls_r && sn.low_side_overcurrent) begin
      skip_nxt = 1'b1;
    end
    if (per_cnt_nxt == '0) begin
      hist_nxt   = {hist_r[OC_WINDOW-2:0], oc_cur_nxt};
      oc_cur_nxt = 1'b0;
      skip_nxt   = 1'b0;
    end
    if (!run_on) begin
      hist_nxt   = '0;
      oc_cur_nxt = 1'b0;
      skip_nxt   = 1'b0;
    end
    if (!run_on || prebias_nxt) begin
      hs_nxt = 1'b0;
    end else if (per_cnt_nxt == '0) begin
      hs_nxt = !skip_r && !sn.low_side_overcurrent;
    end else begin
      hs_nxt = hs_r && !sn.pwm_end && !sn.high_side_overcurrent
             && (per_cnt_nxt < per_eff - PER_W'(MIN_OFF_CYC));
    end
    if (ov_lat_r || ov_trip) begin
      hs_nxt = 1'b0;
      ls_nxt = 1'b1;
    end else begin
      ls_nxt = run_on && !prebias_nxt && !hs_nxt;
    end
  end

  // Gate drive registers.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      per_cnt_r <= '0;
      hs_r      <= 1'b0;
      ls_r      <= 1'b0;
      skip_r    <= 1'b0;
      oc_cur_r  <= 1'b0;
      hist_r    <= '0;
    end else begin
      per_cnt_r <= per_cnt_nxt;
      hs_r      <= hs_nxt;
      ls_r      <= ls_nxt;
      skip_r    <= skip_nxt;
      oc_cur_r  <= oc_cur_nxt;
      hist_r    <= hist_nxt;
    end
  end

  // Regulator supply selection and power-good.
  always_comb begin
    reg_on_nxt = en_deep;
    ext_nxt    = ext_r;
    if (state_r != ST_REGULATE || ov_lat_r) begin
      ext_nxt = 1'b0;
    end else if (sn.vout_above_hi) begin
      ext_nxt = 1'b1;
    end else if (!sn.vout_above_lo) begin
      ext_nxt = 1'b0;
    end
    pg_oe_nxt = !(state_r == ST_REGULATE && !ov_lat_r && !prebias_r
                  && !sn.fb_over_ov && !sn.fb_under_uv && !sn.thermal_trip
                  && !oc_cur_r && !oc_trip);
  end

  // Supply and power-good registers.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_on_r <= 1'b0;
      ext_r    <= 1'b0;
      pg_oe_r  <= 1'b1;
    end else begin
      reg_on_r <= reg_on_nxt;
      ext_r    <= ext_nxt;
      pg_oe_r  <= pg_oe_nxt;
    end
  end

  // Wishbone slave: one wait state, ack for any address, unmapped reads zero.
  logic       wb_go;
  logic [3:0] flt_set;
  assign wb_go   = wb_cyc_i & wb_stb_i & !ack_r;
  assign flt_set = {sn.thermal_trip & (state_r == ST_REGULATE),
                    uv_trip, ov_trip, oc_trip};
  always_comb begin
    ack_nxt     = wb_go;
    ctrl_en_nxt = ctrl_en_r;
    period_nxt  = period_r;
    fault_nxt   = fault_r;
    rdat_nxt    = rdat_r;
    if (wb_go && wb_we_i) begin
      unique case (wb_adr_i)
        ADDR_CTRL: begin
          if (wb_sel_i[0]) begin
            ctrl_en_nxt = wb_dat_i[0];
          end
        end
        ADDR_PERIOD: begin
          if (wb_sel_i[0]) begin
            period_nxt[7:0] = wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            period_nxt[PER_W-1:8] = wb_dat_i[PER_W-1:8];
          end
        end
        ADDR_FAULT: begin
          if (wb_sel_i[0]) begin
            fault_nxt = fault_r & ~wb_dat_i[3:0];
          end
        end
        default: begin
        end
      endcase
    end
    // A fault in the same cycle as its clear stays set.
    fault_nxt = fault_nxt | flt_set;
    if (wb_go && !wb_we_i) begin
      unique case (wb_adr_i)
        ADDR_CTRL:   rdat_nxt = {31'h0, ctrl_en_r};
        ADDR_PERIOD: rdat_nxt = {22'h0, period_r};
        ADDR_STATUS: rdat_nxt = {20'h0, sn.power_good_in, !pg_oe_r, ext_r, reg_on_r,
                                 prebias_r, ov_lat_r, ls_r, hs_r, 1'b0, state_r};
        ADDR_FAULT:  rdat_nxt = {28'h0, fault_r};
        ADDR_SSLEN:  rdat_nxt = 32'(ss_len_r);
        default:     rdat_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Register file registers.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ack_r     <= 1'b0;
      ctrl_en_r <= CTRL_EN_RST;
      period_r  <= PERIOD_RST;
      fault_r   <= '0;
      rdat_r    <= '0;
    end else begin
      ack_r     <= ack_nxt;
      ctrl_en_r <= ctrl_en_nxt;
      period_r  <= period_nxt;
      fault_r   <= fault_nxt;
      rdat_r    <= rdat_nxt;
    end
  end

  // Outputs.
  assign wb_ack_o              = ack_r;
  assign wb_dat_o              = rdat_r;
  assign hs_gate_out           = hs_r;
  assign ls_gate_out           = ls_r;
  assign power_good_out_o      = 1'b0; // Open drain only ever pulls low.
  assign power_good_out_oe     = pg_oe_r;
  assign internal_regulator_on = reg_on_r;
  assign bootstrap_supply_sel  = ext_r;
  assign ramp_phase            = per_cnt_r;

endmodule // bfs_sequencer

// >>> bfs_props.sv
// Checker of the sequencer port behaviour.
`timescale 1ns/1ps
module bfs_props
  import bfs_pkg::*;
(
  input wire logic             clk_sys,
  input wire logic             rst_n,
  input wire bfs_sense_t       sense_in,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_ack_o,
  input wire logic             hs_gate_out,
  input wire logic             ls_gate_out,
  input wire logic             power_good_out_o,
  input wire logic             power_good_out_oe,
  input wire logic             internal_regulator_on,
  input wire logic             bootstrap_supply_sel,
  input wire logic [PER_W-1:0] ramp_phase
);
  logic [5:0] off_cnt_r;
  logic [5:0] off_cnt_nxt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Counts cycles with the high-side switch off, saturating at the top.
  always_comb off_cnt_nxt = hs_gate_out ? 6'h00 : off_cnt_r + {5'h00, off_cnt_r != 6'h3F};
  always_ff @(posedge clk_sys) off_cnt_r <= rst_n ? off_cnt_nxt : 6'h3F;
  // Every high-side pulse follows at least the minimum off time.
  a_min_off: assert property ($rose(hs_gate_out) |-> off_cnt_r >= MIN_OFF_CYC)
    else $error("off time too short");
  a_ramp_step: assert property (ramp_phase != 10'h000 && ramp_phase != $past(ramp_phase)
    |-> ramp_phase == $past(ramp_phase) + 10'h001)
    else $error("ramp not a sawtooth");
  a_en_off: assert property (!(sense_in.en_above_thr || sense_in.en_open) [*6]
    |-> !hs_gate_out && !ls_gate_out)
    else $error("gates on without enable");
  a_deep_off: assert property (!(sense_in.en_deep_above || sense_in.en_open) [*6]
    |-> !internal_regulator_on)
    else $error("regulator on in deep disable");
  // The ramp stays inside the longest allowed period and never wraps early.
  a_ramp_top: assert property (ramp_phase < PER_MAX_CYC)
    else $error("ramp beyond longest period");
  a_ramp_wrap: assert property (ramp_phase == 10'h000 && $past(ramp_phase) != 10'h000
    |-> $past(ramp_phase) >= PER_MIN_CYC - 1)
    else $error("ramp wrapped before shortest period");
  a_thermal_pg: assert property (sense_in.thermal_trip [*6] |-> power_good_out_oe)
    else $error("power good released while hot");
  a_pg_drain: assert property (power_good_out_o == 1'b0)
    else $error("power good driven high");
  a_boot_lo: assert property (!sense_in.vout_above_lo [*6] |-> !bootstrap_supply_sel)
    else $error("bootstrap kept below low level");
  a_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered");
  a_bus_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  c_boot: cover property (bootstrap_supply_sel);
  c_pulse: cover property ($rose(hs_gate_out));
  c_pg: cover property (!power_good_out_oe);
endmodule // bfs_props

// >>> bfs_stage_model.sv
// Model of the power stage and comparators facing the sequencer.
`timescale 1ns/1ps
module bfs_stage_model
  import bfs_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       hs_gate_out,
  input  wire logic       ls_gate_out,
  input  wire logic       power_good_out_oe,
  input  wire logic [9:0] duty_cyc,
  input  wire bfs_sense_t knob,
  output bfs_sense_t      sense_out
);
  logic [9:0] on_cnt_r;
  // Measures how long the high-side switch has conducted.
  always_ff @(posedge clk_sys) on_cnt_r <= hs_gate_out ? on_cnt_r + 10'h001 : 10'h000;
  // Current senses see only a conducting switch; the pin has a pull-up.
  always_comb begin
    sense_out = knob;
    sense_out.pwm_end = hs_gate_out && (on_cnt_r >= duty_cyc);
    sense_out.low_side_overcurrent = ls_gate_out && knob.low_side_overcurrent;
    sense_out.high_side_overcurrent = hs_gate_out && knob.high_side_overcurrent;
    sense_out.power_good_in = !power_good_out_oe;
  end
endmodule // bfs_stage_model

// >>> bfs_sequencer_tb.sv
// Self-checking bench of the buck fault sequencer.
`timescale 1ns/1ps
module bfs_sequencer_tb
  import bfs_pkg::*;
;
  localparam int unsigned SD = 50;
  logic             clk_sys;
  logic             rst_n;
  logic             wb_cyc_i;
  logic             wb_stb_i;
  logic             wb_we_i;
  logic [7:0]       wb_adr_i;
  logic [3:0]       wb_sel_i;
  logic [31:0]      wb_dat_i;
  logic [31:0]      wb_dat_o;
  logic             wb_ack_o;
  logic             hs_gate_out;
  logic             ls_gate_out;
  logic             power_good_out_o;
  logic             power_good_out_oe;
  logic             internal_regulator_on;
  logic             bootstrap_supply_sel;
  logic [PER_W-1:0] ramp_phase;
  logic [9:0]       duty;
  logic [9:0]       per;
  bfs_sense_t       knob;
  bfs_sense_t       sense_in;
  logic [63:0]      exp_q[$];
  int               error_cnt;
  int               n_checks;
  int               cyc_cnt;

  bfs_sequencer #(.START_DELAY(SD)) uut (
    .clk_sys, .rst_n, .sense_in, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .hs_gate_out, .ls_gate_out, .power_good_out_o,
    .power_good_out_oe, .internal_regulator_on, .bootstrap_supply_sel, .ramp_phase
  );
  bfs_stage_model stage (
    .clk_sys, .hs_gate_out, .ls_gate_out, .power_good_out_oe, .duty_cyc(duty), .knob,
    .sense_out(sense_in)
  );

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One classic cycle; a read notes its expected masked word first.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m);
    if (!w)
      exp_q.push_back({m, d & m});
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic st(input logic [31:0] e, input logic [31:0] m);
    bus(1'b0, ADDR_STATUS, e, m);
  endtask

  task automatic fl(input logic [31:0] e, input logic [31:0] m);
    bus(1'b0, ADDR_FAULT, e, m);
  endtask

  // Compares read data with an expected masked word.
  task automatic chk_word(input logic [63:0] e);
    n_checks++;
    if ((wb_dat_o & e[63:32]) !== e[31:0]) begin
      error_cnt++;
      $display("mismatch at %0t: read %h expected %h", $time, wb_dat_o, e[31:0]);
    end
  endtask

  // Free-running system clock.
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Takes the oldest note at every read answer; also cuts a hang short.
  always @(posedge clk_sys) begin
    cyc_cnt <= cyc_cnt + 1;
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
      chk_word(exp_q.pop_front());
    if (cyc_cnt == 80000) begin
      error_cnt++;
      final_report();
    end
  end

  // Main sequence.
  initial begin
    rst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    knob = '0;
    duty = 10'h040;
    void'($urandom(85176));
    per = 10'(200 + $urandom % 801);
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    bus(1'b0, ADDR_CTRL, 32'h1, 32'h1);
    bus(1'b1, 8'h20, 32'h5A5A, 32'h0);
    bus(1'b0, 8'h20, 32'h0, 32'hFFFFFFFF);
    st(32'h0, 32'h337);
    bus(1'b1, ADDR_PERIOD, 32'h32, 32'h0);
    // The register keeps the raw value; the clamp acts on the ramp only.
    bus(1'b0, ADDR_PERIOD, 32'h32, 32'h3FF);
    bus(1'b1, ADDR_PERIOD, 32'h3FF, 32'h0);
    bus(1'b0, ADDR_PERIOD, 32'h3FF, 32'h3FF);
    bus(1'b1, ADDR_PERIOD, {22'h0, per}, 32'h0);
    bus(1'b0, ADDR_PERIOD, {22'h0, per}, 32'h3FF);
    duty <= per / 10'h003;
    knob.en_deep_above <= 1'b1;
    knob.en_above_thr <= 1'b1;
    knob.vin_uvlo_ok <= 1'b1;
    knob.vreg_uvlo_ok <= 1'b1;
    repeat (10) @(posedge clk_sys);
    st(32'h101, 32'h337);
    repeat (SD - 25) @(posedge clk_sys);
    st(32'h1, 32'h7);
    repeat (30) @(posedge clk_sys);
    st(32'h2, 32'h407);
    knob.fb_over_ov <= 1'b1;
    knob.fb_under_uv <= 1'b1;
    knob.thermal_trip <= 1'b1;
    repeat (2500) @(posedge clk_sys);
    st(32'h2, 32'h7);
    fl(32'h0, 32'hE);
    knob <= '{en_deep_above: 1'b1, en_above_thr: 1'b1, vin_uvlo_ok: 1'b1, vreg_uvlo_ok: 1'b1,
              ss_end: 1'b1, vout_above_hi: 1'b1, vout_above_lo: 1'b1, default: 1'b0};
    repeat (4 * per) @(posedge clk_sys);
    st(32'h603, 32'h607);
    knob.vout_above_hi <= 1'b0;
    repeat (10) @(posedge clk_sys);
    st(32'h200, 32'h200);
    knob.vout_above_lo <= 1'b0;
    repeat (10) @(posedge clk_sys);
    st(32'h0, 32'h200);
    knob.fb_over_ov <= 1'b1;
    repeat (480) @(posedge clk_sys);
    fl(32'h0, 32'h2);
    repeat (40) @(posedge clk_sys);
    fl(32'h2, 32'h2);
    st(32'h020, 32'h430);
    knob.fb_over_ov <= 1'b0;
    knob.fb_under_uv <= 1'b1;
    knob.ss_end <= 1'b0;
    repeat (10) @(posedge clk_sys);
    st(32'h4, 32'h437);
    repeat (5000) @(posedge clk_sys);
    st(32'h4, 32'h7);
    bus(1'b1, ADDR_FAULT, 32'hF, 32'h0);
    fl(32'h0, 32'hF);
    repeat (6000) @(posedge clk_sys);
    st(32'h2, 32'h7);
    repeat (2200) @(posedge clk_sys);
    st(32'h2, 32'h407);
    knob.ss_end <= 1'b1;
    repeat (1500) @(posedge clk_sys);
    st(32'h3, 32'h7);
    repeat (600) @(posedge clk_sys);
    st(32'h4, 32'h437);
    fl(32'h4, 32'h4);
    knob.fb_under_uv <= 1'b0;
    knob.ss_end <= 1'b0;
    // The wait is four times the longest soft-start so far, about 3100 cycles.
    repeat (13000) @(posedge clk_sys);
    st(32'h2, 32'h7);
    knob.ss_end <= 1'b1;
    repeat (20) @(posedge clk_sys);
    st(32'h3, 32'h7);
    knob.low_side_overcurrent <= 1'b1;
    repeat (4 * per + 20) @(posedge clk_sys);
    st(32'h4, 32'h437);
    fl(32'h1, 32'h1);
    knob.low_side_overcurrent <= 1'b0;
    knob.ss_end <= 1'b0;
    repeat (13000) @(posedge clk_sys);
    knob.ss_end <= 1'b1;
    repeat (20) @(posedge clk_sys);
    knob.thermal_trip <= 1'b1;
    repeat (10) @(posedge clk_sys);
    st(32'h4, 32'h437);
    fl(32'h8, 32'h8);
    knob.thermal_trip <= 1'b0;
    knob.en_deep_above <= 1'b0;
    knob.en_above_thr <= 1'b0;
    repeat (10) @(posedge clk_sys);
    st(32'h0, 32'h137);
    knob.en_deep_above <= 1'b1;
    knob.en_open <= 1'b1;
    knob.fb_above_ref <= 1'b1;
    repeat (10) @(posedge clk_sys);
    st(32'h1, 32'h7);
    repeat (60) @(posedge clk_sys);
    st(32'h82, 32'hB7);
    final_report();
  end
endmodule // bfs_sequencer_tb

bind bfs_sequencer bfs_props chk (
  .clk_sys, .rst_n, .sense_in, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .hs_gate_out, .ls_gate_out,
  .power_good_out_o, .power_good_out_oe, .internal_regulator_on, .bootstrap_supply_sel,
  .ramp_phase
);
